// file: design/lcd_serial_defines.svh
/*
  Constants for the two-wire display command port: slave address, control byte
  layout, display defaults, master register map and bus timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LCD_SERIAL_DEFINES_SVH
`define LCD_SERIAL_DEFINES_SVH
// fixed upper six bits of the slave address
`define SLAVE_ADDR_HI  6'h1D
// control byte flag positions
`define CTL_CO_BIT     7
`define CTL_RS_BIT     6
`define CTL_RW_BIT     5
// text memory size and the code it holds after reset
`define TEXT_DEPTH     80
`define BLANK_CHAR     8'h20
// master register byte offsets
`define CMD_OFS        4'h0
`define STATUS_OFS     4'h4
// command register fields
`define CMD_OP_LSB     0
`define CMD_DATA_LSB   8
`define CMD_NACK_BIT   16
// status register fields
`define ST_BUSY_BIT    0
`define ST_NACK_BIT    1
`define ST_RX_LSB      8
// bus timing: clock rate, serial rate, half period in clock cycles
`define MCLK_HZ        125000000
`define SCL_HZ         100000
`define SCL_HALF_CYC   ((`MCLK_HZ / `SCL_HZ) / 2)
`endif

// file: design/lcd_serial_pkg.sv
/*
  Types shared by both ends of the display command link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lcd_serial_pkg;
  // device receive/transmit state, gray along idle-addr-write-read-skip
  typedef enum logic [2:0] {
    dev_idle  = 3'b000,
    dev_addr  = 3'b001,
    dev_write = 3'b011,
    dev_read  = 3'b010,
    dev_skip  = 3'b110
  } dev_state_type;
  // master command opcodes
  typedef enum logic [1:0] {
    op_start = 2'h0,
    op_stop  = 2'h1,
    op_wr    = 2'h2,
    op_rd    = 2'h3
  } op_type;
  // master bus sequencer states
  typedef enum logic [3:0] {
    h_idle    = 4'h0,
    h_st_rel  = 4'h1,
    h_st_sclh = 4'h3,
    h_st_sdal = 4'h2,
    h_st_scll = 4'h6,
    h_sp_sdal = 4'h7,
    h_sp_sclh = 4'h5,
    h_sp_rel  = 4'h4,
    h_b_fall  = 4'hC,
    h_b_data  = 4'hD,
    h_b_high  = 4'hF
  } host_state_type;
endpackage

// file: design/lcd_serial_if.sv
/*
  Two-wire link between the bus master and the display port.
  Both lines are open drain; the wired level is resolved here from the enables.
*/
`timescale 1ns/100ps
interface lcd_serial_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-ups: a line is low when any enabled driver pulls it low
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                output host_sda_oe, input scl, input sda);
  modport dev  (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// file: design/lcd_serial_command_port.sv
/*
  Display end of the two-wire link: slave address match, control byte parsing,
  instruction execution, text memory writes and reads with prefetch.
  Assumes scl and sda are synchronous to mclk and change slowly against it.
*/
`timescale 1ns/100ps
`include "lcd_serial_defines.svh"
module lcd_serial_command_port
  import lcd_serial_pkg::*;
#(
  parameter int DEPTH = `TEXT_DEPTH
) (
  // clock and reset
  input  logic       mclk,
  input  logic       rst_n,
  // link
  lcd_serial_if.dev  bus,
  // strap
  input  logic       address_select_pin,
  // display refresh side
  input  logic [6:0] view_addr,
  output logic [7:0] view_data,
  output logic [6:0] cursor_addr,
  output logic [6:0] shift_offset,
  output logic       display_on,
  output logic       cursor_on,
  output logic       blink_on,
  output logic       two_line
);
  if (DEPTH < 2 || DEPTH > 128) begin : g_chk
    $error("DEPTH must be 2 to 128");
  end

  dev_state_type st_r;
  logic [3:0]    cnt_r;
  logic [7:0]    sh_in_r;
  logic [7:0]    sh_out_r;
  logic [7:0]    data_holding_reg_r;
  logic [6:0]    text_address_counter_r;
  logic [6:0]    ofs_r;
  logic          scl_q_r;
  logic          sda_q_r;
  logic          sda_oe_r;
  logic          ctrl_due_r;
  logic          continuation_flag_r;
  logic          register_select_r;
  logic          rw_flag_r;
  logic          text_sel_r;
  logic          disp_r;
  logic          curs_r;
  logic          blink_r;
  logic          lines_r;
  logic          inc_r;
  logic          dshift_r;
  logic [7:0]    view_r;
  logic [7:0]    display_text_memory [DEPTH];

  // wrap-around step used by the address counter and the display shift
  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    if (up) begin
      step = (a == 7'(DEPTH - 1)) ? 7'h00 : 7'(a + 7'h01);
    end else begin
      step = (a == 7'h00) ? 7'(DEPTH - 1) : 7'(a - 7'h01);
    end
  endfunction

  // line events; scl and sda are taken as synchronous, one sample of history
  wire scl_rise  = bus.scl && !scl_q_r;
  wire scl_fall  = !bus.scl && scl_q_r;
  wire start_ev  = bus.scl && scl_q_r && sda_q_r && !bus.sda;
  wire stop_ev   = bus.scl && scl_q_r && !sda_q_r && bus.sda;
  wire ack_rise  = scl_rise && (cnt_r == 4'h8);
  wire addr_hit  = (sh_in_r[7:1] == {`SLAVE_ADDR_HI, address_select_pin});
  wire rd_req    = sh_in_r[0];
  wire ctl_en    = ack_rise && (st_r == dev_write) && ctrl_due_r;
  wire exec_en   = ack_rise && (st_r == dev_write) && !ctrl_due_r;
  wire addr_rd   = ack_rise && (st_r == dev_addr) && addr_hit && rd_req;
  wire rd_ack    = ack_rise && (st_r == dev_read) && !bus.sda;
  wire [6:0] ac_next  = step(text_address_counter_r, inc_r);
  wire [7:0] pf_data  = display_text_memory[ac_next];
  wire [6:0] set_addr = ({1'b0, sh_in_r[6:0]} < 8'(DEPTH)) ? sh_in_r[6:0] : 7'h00;
  wire       wr_char  = exec_en && !rw_flag_r && register_select_r;
  wire       wr_mem   = wr_char && text_sel_r;
  wire       instr    = exec_en && !rw_flag_r && !register_select_r;
  wire [7:0] rd_first = register_select_r ? data_holding_reg_r : {1'b0, text_address_counter_r};
  wire       ack_drv  = ((st_r == dev_addr) && addr_hit) || (st_r == dev_write);
  // state after an acknowledge slot ends
  wire dev_state_type st_after = (st_r == dev_addr) ?
                                 (!addr_hit ? dev_skip : (rd_req ? dev_read : dev_write)) : st_r;

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe_r;
  assign view_data      = view_r;
  assign cursor_addr    = text_address_counter_r;
  assign shift_offset   = ofs_r;
  assign display_on     = disp_r;
  assign cursor_on      = curs_r;
  assign blink_on       = blink_r;
  assign two_line       = lines_r;

  // bit framing: start and stop win over any bit activity
  always_ff @(posedge mclk) begin
    scl_q_r <= bus.scl;
    sda_q_r <= bus.sda;
    if (!rst_n) begin
      st_r     <= dev_idle;
      cnt_r    <= 4'h0;
      sh_in_r  <= 8'h00;
      sh_out_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      st_r     <= dev_addr;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      st_r     <= dev_idle;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (scl_rise && cnt_r < 4'h8) begin
      sh_in_r <= {sh_in_r[6:0], bus.sda};
      cnt_r   <= 4'(cnt_r + 4'h1);
      if (st_r == dev_read) begin
        sh_out_r <= {sh_out_r[6:0], 1'b0};
      end
    end else if (ack_rise) begin
      cnt_r <= 4'h9;
      if (addr_rd) begin
        sh_out_r <= rd_first;
      end else if (rd_ack) begin
        sh_out_r <= pf_data;
      end else if (st_r == dev_read) begin
        st_r <= dev_skip;
      end
    end else if (scl_fall) begin
      if (cnt_r == 4'h8) begin
        sda_oe_r <= ack_drv;
      end else if (cnt_r == 4'h9) begin
        cnt_r    <= 4'h0;
        st_r     <= st_after;
        sda_oe_r <= (st_after == dev_read) && !sh_out_r[7];
      end else if (st_r == dev_read && cnt_r != 4'h0) begin
        sda_oe_r <= !sh_out_r[7];
      end
    end
  end

  // control byte, instruction execution and read-side counter updates
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_due_r             <= 1'b1;
      continuation_flag_r    <= 1'b0;
      register_select_r      <= 1'b0;
      rw_flag_r              <= 1'b0;
      text_sel_r             <= 1'b1;
      text_address_counter_r <= 7'h00;
      data_holding_reg_r     <= 8'h00;
      ofs_r                  <= 7'h00;
      disp_r                 <= 1'b0;
      curs_r                 <= 1'b0;
      blink_r                <= 1'b0;
      lines_r                <= 1'b0;
      inc_r                  <= 1'b1;
      dshift_r               <= 1'b0;
    end else begin
      if (start_ev) begin
        ctrl_due_r <= 1'b1;
      end
      if (ctl_en) begin
        // flags latched here hold until the next control byte, which follows each data byte while the continuation flag is set
        continuation_flag_r <= sh_in_r[`CTL_CO_BIT];
        register_select_r   <= sh_in_r[`CTL_RS_BIT];
        rw_flag_r           <= sh_in_r[`CTL_RW_BIT];
        ctrl_due_r          <= 1'b0;
      end
      if (exec_en) begin
        ctrl_due_r <= continuation_flag_r;
      end
      if (wr_char) begin
        text_address_counter_r <= ac_next;
        if (dshift_r) begin
          ofs_r <= step(ofs_r, inc_r);
        end
      end
      if (instr) begin
        casez (sh_in_r)
          8'b1???????: begin
            text_sel_r             <= 1'b1;
            text_address_counter_r <= set_addr;
            data_holding_reg_r     <= display_text_memory[set_addr];
          end
          8'b01??????: begin
            // pattern memory is not kept; its writes only move the counter and, with display shift on, the shift offset
            text_sel_r             <= 1'b0;
            text_address_counter_r <= {1'b0, sh_in_r[5:0]};
          end
          8'b001?????: lines_r <= sh_in_r[3];
          8'b0001????: begin
            if (sh_in_r[3]) begin
              ofs_r <= step(ofs_r, sh_in_r[2]);
            end else begin
              text_address_counter_r <= step(text_address_counter_r, sh_in_r[2]);
            end
          end
          8'b00001???: begin
            disp_r  <= sh_in_r[2];
            curs_r  <= sh_in_r[1];
            blink_r <= sh_in_r[0];
          end
          8'b000001??: begin
            inc_r    <= sh_in_r[1];
            dshift_r <= sh_in_r[0];
          end
          8'b0000001?: begin
            text_address_counter_r <= 7'h00;
            ofs_r                  <= 7'h00;
          end
          default: begin
          end
        endcase
      end
      if (rd_ack) begin
        text_address_counter_r <= ac_next;
        data_holding_reg_r     <= pf_data;
      end
    end
  end

  // text memory: blanks from reset, one write port, registered refresh port
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        display_text_memory[i] <= `BLANK_CHAR;
      end
      view_r <= 8'h00;
    end else begin
      if (wr_mem) begin
        display_text_memory[text_address_counter_r] <= sh_in_r;
      end
      // eight-bit compare so that a full 128-entry memory is not clamped
      view_r <= ({1'b0, view_addr} < 8'(DEPTH)) ? display_text_memory[view_addr] : 8'h00;
    end
  end
endmodule

// file: design/lcd_serial_master.sv
/*
  Bus master end of the display link: an Avalon-MM slave with two registers
  that sequences start, stop and nine-bit byte transfers on scl and sda.
  Assumes the display never stretches scl; the master does not wait for it.
*/
`timescale 1ns/100ps
`include "lcd_serial_defines.svh"
module lcd_serial_master
  import lcd_serial_pkg::*;
#(
  parameter int HALF_CYC = `SCL_HALF_CYC
) (
  // clock and reset
  input  logic        mclk,
  input  logic        rst_n,
  // avalon-mm slave
  input  logic [3:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // link
  lcd_serial_if.host  bus
);
  if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_chk
    $error("HALF_CYC must be 4 to 65535");
  end
  localparam logic [15:0] HALF_LD = 16'(HALF_CYC - 1);

  host_state_type st_r;
  logic [15:0]    tmr_r;
  logic [3:0]     bit_r;
  logic [8:0]     tx_r;
  logic [8:0]     rx_r;
  logic [31:0]    cmd_r;
  logic [31:0]    rdata_r;
  logic           wait_r;
  logic           scl_oe_r;
  logic           sda_oe_r;

  // one wait state: request seen with waitrequest high, finished next edge
  wire       req      = avs_read || avs_write;
  wire       wait_nxt = !(req && wait_r);
  wire       busy     = (st_r != h_idle);
  wire       cmd_take = avs_write && !wait_r && (avs_address == `CMD_OFS) && !busy;
  wire       rd_take  = avs_read && wait_r;
  wire       tick     = (tmr_r == 16'h0000);
  wire op_type cmd_op = op_type'(avs_writedata[`CMD_OP_LSB +: 2]);
  wire [7:0] cmd_data = avs_writedata[`CMD_DATA_LSB +: 8];
  wire [31:0] status  = {16'h0000, rx_r[8:1], 6'h00, rx_r[0], busy};
  wire [31:0] rd_mux  = (avs_address == `CMD_OFS)    ? cmd_r :
                        (avs_address == `STATUS_OFS) ? status : 32'h0000_0000;

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_oe = sda_oe_r;

  // register access; a command written while busy is dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      cmd_r   <= 32'h0000_0000;
    end else begin
      wait_r <= wait_nxt;
      if (rd_take) begin
        rdata_r <= rd_mux;
      end
      if (cmd_take) begin
        cmd_r <= avs_writedata;
      end
    end
  end

  // line sequencer: each state holds its line levels for one half period
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r     <= h_idle;
      tmr_r    <= 16'h0000;
      bit_r    <= 4'h0;
      tx_r     <= 9'h1FF;
      rx_r     <= 9'h000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (cmd_take) begin
      tmr_r <= HALF_LD;
      case (cmd_op)
        op_start: begin
          sda_oe_r <= 1'b0;  // also serves as repeated start from scl low
          st_r     <= h_st_rel;
        end
        op_stop: begin
          sda_oe_r <= 1'b1;
          st_r     <= h_sp_sdal;
        end
        default: begin
          // write sends data and releases for ack; read releases and answers
          tx_r     <= (cmd_op == op_wr) ? {cmd_data, 1'b1}
                                        : {8'hFF, avs_writedata[`CMD_NACK_BIT]};
          bit_r    <= 4'h0;
          scl_oe_r <= 1'b1;
          st_r     <= h_b_fall;
        end
      endcase
    end else if (busy && !tick) begin
      tmr_r <= 16'(tmr_r - 16'h0001);
    end else if (busy) begin
      tmr_r <= HALF_LD;
      case (st_r)
        h_st_rel: begin
          scl_oe_r <= 1'b0;
          st_r     <= h_st_sclh;
        end
        h_st_sclh: begin
          sda_oe_r <= 1'b1;
          st_r     <= h_st_sdal;
        end
        h_st_sdal: begin
          scl_oe_r <= 1'b1;
          st_r     <= h_st_scll;
        end
        h_sp_sdal: begin
          scl_oe_r <= 1'b0;
          st_r     <= h_sp_sclh;
        end
        h_sp_sclh: begin
          sda_oe_r <= 1'b0;
          st_r     <= h_sp_rel;
        end
        h_b_fall: begin
          if (bit_r == 4'h9) begin
            st_r <= h_idle;
          end else begin
            sda_oe_r <= !tx_r[8];
            st_r     <= h_b_data;
          end
        end
        h_b_data: begin
          scl_oe_r <= 1'b0;
          st_r     <= h_b_high;
        end
        h_b_high: begin
          rx_r     <= {rx_r[7:0], bus.sda};
          tx_r     <= {tx_r[7:0], 1'b1};
          bit_r    <= 4'(bit_r + 4'h1);
          scl_oe_r <= 1'b1;
          st_r     <= h_b_fall;
        end
        default: st_r <= h_idle;
      endcase
    end
  end
endmodule

// file: bench/lcd_serial_properties.sv
/*
  Wire-level checker for the display link: decodes start, stop, bit count
  and the address byte from scl and sda, and checks the display's sda use.
  Assumes scl and sda change slowly against mclk and the strap is wired in.
*/
`timescale 1ns/100ps
module lcd_serial_properties (
  // clock and reset
  input logic mclk,
  input logic rst_n,
  // strap that sets the lowest address bit
  input logic address_select_pin,
  // link
  input logic host_scl_o,
  input logic host_scl_oe,
  input logic host_sda_o,
  input logic host_sda_oe,
  input logic dev_sda_o,
  input logic dev_sda_oe,
  input logic scl,
  input logic sda
);
  logic       scl_q, sda_q, in_xfer_r, first_r, rd_r, acc_r, nak_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  // conditions seen with scl high; bit slot 9 is the acknowledge
  wire        start_c = scl && scl_q && sda_q && !sda;
  wire        stop_c  = scl && scl_q && !sda_q && sda;
  wire        rise_c  = scl && !scl_q;
  wire        match_c = (sh_r[7:1] == {6'h1D, address_select_pin});
  // ack slot with scl already high; the rise edge itself belongs to the old slot
  wire        ack_hi  = (bit_r == 4'h9) && scl && scl_q;
  // byte framing; the address verdict is latched so later bytes know it
  always_ff @(posedge mclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_n) begin
      in_xfer_r <= 1'h0;
      first_r <= 1'h0;
      rd_r <= 1'h0;
      acc_r <= 1'h0;
      nak_r <= 1'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
    end else if (start_c) begin
      in_xfer_r <= 1'h1;
      first_r <= 1'h1;
      nak_r <= 1'h0;
      bit_r <= 4'h0;
    end else if (stop_c) begin
      in_xfer_r <= 1'h0;
      nak_r <= 1'h0;
    end else if (rise_c) begin
      bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
      if (bit_r == 4'h9) first_r <= 1'h0;
      if (bit_r < 4'h8) sh_r <= {sh_r[6:0], sda};
      if (first_r && bit_r == 4'h8) rd_r <= sh_r[0];
      if (first_r && bit_r == 4'h8) acc_r <= match_c;
      // master left sda high in a read ack slot: the read is over
      if (acc_r && rd_r && !first_r && bit_r == 4'h8 && sda) nak_r <= 1'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_addr_time;
    first_r && bit_r == 4'h8 && $fell(scl) && match_c |-> ##[1:3] dev_sda_oe;
  endproperty
  a_addr_time: assert property (p_addr_time) else $error("no address ack");
  property p_addr_level;
    first_r && ack_hi |-> dev_sda_oe == match_c;
  endproperty
  a_addr_level: assert property (p_addr_level) else $error("address ack wrong");
  property p_wr_ack;
    acc_r && !rd_r && !first_r && in_xfer_r && ack_hi |-> dev_sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
  property p_rd_rel;
    acc_r && rd_r && !first_r && ack_hi |-> !dev_sda_oe;
  endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("sda held in master ack");
  property p_quiet;
    in_xfer_r && first_r && bit_r < 4'h8 |-> !dev_sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("sda driven in address");
  property p_idle;
    !in_xfer_r |-> !dev_sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("sda driven while idle");
  property p_hold;
    scl && scl_q |-> $stable(dev_sda_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("sda moved with scl high");
  property p_dev_od;
    dev_sda_o == 1'h0;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("sda driven high");
  property p_nack_quiet;
    nak_r |-> !dev_sda_oe;
  endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("sda after nack");
  c_ack: cover property (first_r && ack_hi && match_c);
  c_read: cover property (acc_r && rd_r && !first_r && ack_hi);
  c_nack: cover property (nak_r);
  c_stop: cover property (stop_c);
endmodule

// file: bench/lcd_serial_command_port_tb.sv
/*
  Self-checking bench: master and display ends joined by the link, driven
  over Avalon-MM. Assumes a short serial half period and strap low at first.
*/
`timescale 1ns/100ps
`include "lcd_serial_defines.svh"
module lcd_serial_command_port_tb
  import lcd_serial_pkg::*;
;
  logic        mclk, rst_n, sel, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, st;
  logic [6:0]  view_addr, cursor_addr, shift_offset;
  logic [7:0]  view_data;
  logic        display_on, cursor_on, blink_on, two_line;
  int          fails, n_tests;
  lcd_serial_if lnk();
  lcd_serial_master #(.HALF_CYC(8)) i_lcd_serial_master (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus(lnk));
  lcd_serial_command_port i_lcd_serial_command_port (.mclk(mclk), .rst_n(rst_n), .bus(lnk),
    .address_select_pin(sel), .view_addr(view_addr), .view_data(view_data),
    .cursor_addr(cursor_addr), .shift_offset(shift_offset), .display_on(display_on),
    .cursor_on(cursor_on), .blink_on(blink_on), .two_line(two_line));
  lcd_serial_properties i_lcd_serial_properties (.mclk(mclk), .rst_n(rst_n),
    .address_select_pin(sel),
    .host_scl_o(lnk.host_scl_o), .host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o),
    .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe),
    .scl(lnk.scl), .sda(lnk.sda));
  // 125 MHz
  always #4 mclk = ~mclk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one Avalon cycle; request held until waitrequest is sampled low
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 40);
    if (k >= 40) begin
      fails++;
      summarize();
    end
    st = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge mclk);
  endtask
  // a command is followed by busy polling, so the next never gets dropped
  task automatic op(input op_type o, input logic [7:0] b, input logic nk);
    int k;
    av(`CMD_OFS, 1'h1, {15'h0000, nk, b, 6'h00, o});
    k = 0;
    do begin
      av(`STATUS_OFS, 1'h0, 32'h0000_0000);
      k++;
    end while (st[0] !== 1'h0 && k < 400);
    if (k >= 400) begin
      fails++;
      summarize();
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic nak);
    op(op_wr, b, 1'h0);
    chk("byte ack", {7'h00, nak}, {7'h00, st[1]});
  endtask
  task automatic mem(input logic [6:0] a, input logic [7:0] e);
    view_addr <= a;
    repeat (2) @(posedge mclk);
    chk("text memory", e, view_data);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 80; i++) mem(7'(i), 8'h20);
    chk("display off", 8'h00, {7'h00, display_on});
  endtask
  // instructions in one continued transfer; none lands in text memory
  task automatic t_init();
    op(op_start, 8'h00, 1'h0);
    wb(8'h74, 1'h0);
    wb(8'h00, 1'h0);
    wb(8'h38, 1'h0);
    chk("two line", 8'h01, {7'h00, two_line});
    wb(8'h30, 1'h0);
    chk("single line", 8'h00, {7'h00, two_line});
    wb(8'h0E, 1'h0);
    chk("display on", 8'h06, {5'h00, display_on, cursor_on, blink_on});
    wb(8'h06, 1'h0);
    mem(7'h00, 8'h20);
  endtask
  task automatic t_write();
    logic [7:0] s [3];
    s = '{8'h50, 8'h48, 8'h49};
    op(op_start, 8'h00, 1'h0);
    wb(8'h74, 1'h0);
    wb(8'h40, 1'h0);
    for (int i = 0; i < 3; i++) wb(s[i], 1'h0);
    chk("counter", 8'h03, {1'h0, cursor_addr});
    chk("no shift", 8'h00, {1'h0, shift_offset});
    for (int i = 0; i < 3; i++) mem(7'(i), s[i]);
    op(op_stop, 8'h00, 1'h0);
  endtask
  // return home, then read with prefetch; the first byte is not defined
  task automatic t_read();
    op(op_start, 8'h00, 1'h0);
    wb(8'h74, 1'h0);
    wb(8'h80, 1'h0);
    wb(8'h02, 1'h0);
    chk("home", 8'h00, {1'h0, cursor_addr});
    mem(7'h01, 8'h48);
    wb(8'h60, 1'h0);
    op(op_start, 8'h00, 1'h0);
    wb(8'h75, 1'h0);
    op(op_rd, 8'h00, 1'h0);
    op(op_rd, 8'h00, 1'h0);
    chk("read next", 8'h48, st[15:8]);
    chk("read advance", 8'h02, {1'h0, cursor_addr});
    op(op_rd, 8'h00, 1'h1);
    chk("read last", 8'h49, st[15:8]);
    chk("no advance", 8'h02, {1'h0, cursor_addr});
    op(op_stop, 8'h00, 1'h0);
  endtask
  // address set refreshes the holding register, so the first read is defined
  task automatic t_set();
    op(op_start, 8'h00, 1'h0);
    wb(8'h74, 1'h0);
    wb(8'h80, 1'h0);
    wb(8'h81, 1'h0);
    chk("address set", 8'h01, {1'h0, cursor_addr});
    wb(8'h60, 1'h0);
    op(op_start, 8'h00, 1'h0);
    wb(8'h75, 1'h0);
    op(op_rd, 8'h00, 1'h0);
    chk("read first", 8'h48, st[15:8]);
    op(op_rd, 8'h00, 1'h1);
    chk("read prefetch", 8'h49, st[15:8]);
    op(op_stop, 8'h00, 1'h0);
  endtask
  task automatic t_addr();
    logic [7:0] bad [3];
    bad = '{8'h76, 8'h54, 8'hF4};
    for (int i = 0; i < 3; i++) begin
      op(op_start, 8'h00, 1'h0);
      wb(bad[i], 1'h1);
    end
    op(op_stop, 8'h00, 1'h0);
    sel <= 1'h1;
    op(op_start, 8'h00, 1'h0);
    wb(8'h76, 1'h0);
    op(op_stop, 8'h00, 1'h0);
  endtask
  // reset for three edges, then the scenarios in order
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    sel = 1'h0;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0000_0000;
    view_addr = 7'h00;
    fails = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    t_reset();
    t_init();
    t_write();
    t_read();
    t_set();
    t_addr();
    summarize();
  end
endmodule
